// >>> logic/listen_addr_defines.svh
/*
 Constants for the bus listen address configuration block.
 Assumes inclusion by bare name from the package and design files.
*/
`ifndef LISTEN_ADDR_DEFINES_SVH
`define LISTEN_ADDR_DEFINES_SVH
`define ADDR_W 5
`define ADDR_MAX 5'h1E
`define ADDR_ALL_ONES 5'h1F
`define ADDR_FACTORY 5'h07
`define LISTEN_BASE 8'h20
`define LISTEN_GROUP_MASK 8'hE0
`define UNLISTEN_CMD 8'h3F
`define LOAD_WAIT 2'h3
`define SYNC_FILL 2'h2
`endif

// >>> logic/listen_addr_pkg.sv
/*
 Types for the bus listen address configuration block.
 Assumes the defines header is on the include path.
*/
`default_nettype none
`include "listen_addr_defines.svh"
package listen_addr_pkg;
   typedef logic [`ADDR_W-1:0] addr_t;
   typedef struct packed
   {
      logic atn;
      logic valid;
      logic [7:0] data;
   } bus_byte_s;
   typedef enum logic [1:0] {ST_SETTLE, ST_LOAD, ST_RUN} load_e;
endpackage
`default_nettype wire

// >>> logic/listen_addr_config.sv
/*
 Listen-only bus address configuration: captures the switch address after
 reset, maps it to its listen character and gates received data bytes.
 Assumes switch pins are asynchronous and that bus bytes arrive already
 synchronised to mclk as one-cycle valid strobes with attention flagged.
*/
// How it works
// RQ1 - Device is listener only; it holds a listen address and never talks.
// RQ2 - Address bits come from switches, first switch lsb, fifth switch msb.
// RQ3 - Addresses 00 to 30 are valid; switch values above 30 are invalid.
// RQ4 - Factory preset address is decimal 07, pattern 00111.
// RQ5 - Switches load into stored address only at power-up or reset.
// RQ6 - Listen character equals address plus space; 00 is space, 30 is '>'.
// RQ7 - All switches one (31) stores address 30 instead.
// RQ8 - Switch on set side reads one, clear side reads zero.
// RQ9 - Data bytes accepted only after a matching listen command.
`default_nettype none
`include "listen_addr_defines.svh"
module listen_addr_config
   import listen_addr_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic address_switch_lsb,
   input wire logic [2:0] address_switch_mid,
   input wire logic address_switch_msb,
   input wire bus_byte_s bus_in,
   output logic [`ADDR_W-1:0] listen_addr,
   output logic [7:0] listen_char,
   output logic addr_loaded,
   output logic switch_invalid,
   output logic listening,
   output logic talk_enable,
   output logic [7:0] rx_data,
   output logic rx_valid
);
   addr_t sw_meta_r;
   addr_t sw_sync_r;
   addr_t addr_r;
   logic [7:0] char_r;
   logic inval_r;
   logic lacs_r;
   logic [7:0] rx_data_r;
   logic rx_valid_r;
   logic [1:0] wait_r;
   load_e state_r;
   load_e state_nxt;
   logic loaded_r;
   logic talk_r;
   wire addr_t sw_raw;
   wire addr_t sw_fixed;
   wire logic sw_over;
   wire logic load_now;
   wire logic [7:0] char_nxt;
   wire logic is_my_listen;
   wire logic is_unlisten;
   wire logic is_other_listen;
   wire logic data_take;

   // Set side of each switch drives a one
   assign sw_raw = {address_switch_msb, address_switch_mid, address_switch_lsb}; // RQ2 RQ8
   assign sw_over = (sw_sync_r > `ADDR_MAX); // RQ3
   assign sw_fixed = (sw_sync_r == `ADDR_ALL_ONES) ? `ADDR_MAX : sw_sync_r; // RQ7
   assign load_now = (state_r == ST_LOAD);
   assign char_nxt = `LISTEN_BASE + {3'h0, sw_fixed}; // RQ6
   assign is_my_listen = bus_in.valid && bus_in.atn && (bus_in.data == char_r); // RQ9
   assign is_unlisten = bus_in.valid && bus_in.atn && (bus_in.data == `UNLISTEN_CMD);
   // Unlisten shares the listen group code space, so it is kept apart here
   assign is_other_listen = bus_in.valid && bus_in.atn
      && ((bus_in.data & `LISTEN_GROUP_MASK) == `LISTEN_BASE)
      && !is_my_listen && !is_unlisten;
   assign data_take = bus_in.valid && !bus_in.atn && lacs_r && load_now == 1'b0
      && state_r == ST_RUN; // RQ9

   // Two stages before the switches are read
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         sw_meta_r <= '0;
         sw_sync_r <= '0;
      end
      else
      begin
         sw_meta_r <= sw_raw;
         sw_sync_r <= sw_meta_r;
      end
   end

   // Waits for the synchroniser to fill, loads once, then ignores switches
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_SETTLE: if (wait_r == `LOAD_WAIT) state_nxt = ST_LOAD;
         ST_LOAD: state_nxt = ST_RUN;
         ST_RUN: state_nxt = ST_RUN; // RQ5
         default: state_nxt = ST_SETTLE;
      endcase
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state_r <= ST_SETTLE;
         wait_r <= 2'h0;
         loaded_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         loaded_r <= (state_nxt == ST_RUN);
         if (state_r == ST_SETTLE)
            wait_r <= wait_r + 2'h1;
      end
   end

   // Factory value stands until the first load after reset
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         addr_r <= `ADDR_FACTORY; // RQ4
         char_r <= `LISTEN_BASE + {3'h0, `ADDR_FACTORY};
         inval_r <= 1'b0;
      end
      else if (load_now) // RQ5
      begin
         addr_r <= sw_fixed; // RQ7
         char_r <= char_nxt; // RQ6
         inval_r <= sw_over; // RQ3
      end
   end

   // Listener state; a new listen of another device does not unaddress us
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         lacs_r <= 1'b0;
         rx_data_r <= 8'h00;
         rx_valid_r <= 1'b0;
         talk_r <= 1'b0;
      end
      else
      begin
         // Listen-only: the talker flag never leaves its reset value
         talk_r <= 1'b0; // RQ1
         if (state_r != ST_RUN || is_unlisten)
            lacs_r <= 1'b0;
         else if (is_my_listen)
            lacs_r <= 1'b1; // RQ9
         rx_valid_r <= data_take;
         if (data_take)
            rx_data_r <= bus_in.data;
      end
   end

   assign listen_addr = addr_r;
   assign listen_char = char_r;
   assign addr_loaded = loaded_r;
   assign switch_invalid = inval_r;
   assign listening = lacs_r;
   assign talk_enable = talk_r; // RQ1
   assign rx_data = rx_data_r;
   assign rx_valid = rx_valid_r;

   // Load, stored address, talker and receive gate checks

   AST_LOAD_LATENCY: assert property (@(posedge mclk) disable iff (reset) // RQ5
      $rose(state_r == ST_RUN) |-> listen_addr == $past(sw_fixed))
      else $error("Stored address not taken from switches at load");
   AST_HOLD: assert property (@(posedge mclk) disable iff (reset) // RQ5
      $past(state_r == ST_RUN) |-> $stable(addr_r))
      else $error("Stored address changed after load");
   AST_RANGE: assert property (@(posedge mclk) disable iff (reset) // RQ3
      addr_r <= `ADDR_MAX)
      else $error("Stored address above 30");
   AST_ALL_ONES: assert property (@(posedge mclk) disable iff (reset) // RQ7
      load_now && sw_sync_r == `ADDR_ALL_ONES |=> addr_r == `ADDR_MAX)
      else $error("All-ones switches did not store 30");
   AST_CHAR: assert property (@(posedge mclk) disable iff (reset) // RQ6
      char_r == `LISTEN_BASE + {3'h0, addr_r})
      else $error("Listen character does not match address");
   AST_FACTORY: assert property (@(posedge mclk) disable iff (reset) // RQ4
      state_r == ST_SETTLE |-> addr_r == `ADDR_FACTORY)
      else $error("Factory address missing before load");
   AST_NO_TALK: assert property (@(posedge mclk) disable iff (reset) // RQ1
      !talk_enable)
      else $error("Talker enabled");
   AST_RX_GATE: assert property (@(posedge mclk) disable iff (reset) // RQ9
      rx_valid |-> $past(lacs_r) && $past(bus_in.valid) && !$past(bus_in.atn))
      else $error("Data accepted while not addressed");
   // Synchroniser holds reset zeros for the first two edges after release
   AST_BIT_ORDER: assert property (@(posedge mclk) disable iff (reset) // RQ2
      state_r != ST_SETTLE || wait_r >= `SYNC_FILL |->
      sw_sync_r[0] == $past(address_switch_lsb, 2)
      && sw_sync_r[`ADDR_W-1] == $past(address_switch_msb, 2))
      else $error("Switch bit order wrong");
   AST_INVALID: assert property (@(posedge mclk) disable iff (reset) // RQ3
      $rose(state_r == ST_RUN) |-> switch_invalid == $past(sw_sync_r == `ADDR_ALL_ONES))
      else $error("Invalid flag does not match switch value at load");

   // Listener steps: addressed by our listen code, released by unlisten
   sequence s_listen_cmd;
      state_r == ST_RUN && is_my_listen;
   endsequence
   sequence s_unlisten_cmd;
      is_unlisten;
   endsequence

   AST_LISTEN_SET: assert property (@(posedge mclk) disable iff (reset) // RQ9
      s_listen_cmd |=> listening)
      else $error("Matching listen command did not address the device");
   AST_UNLISTEN: assert property (@(posedge mclk) disable iff (reset) // RQ9
      s_unlisten_cmd |=> !listening)
      else $error("Unlisten command did not release the device");
   AST_OTHER_KEEP: assert property (@(posedge mclk) disable iff (reset) // RQ9
      is_other_listen |=> listening == $past(listening))
      else $error("Listen of another address changed listener state");
   AST_NOT_LOADED: assert property (@(posedge mclk) disable iff (reset) // RQ9
      !addr_loaded |-> !listening && !rx_valid)
      else $error("Bus activity before the address was loaded");
   AST_RX_DATA: assert property (@(posedge mclk) disable iff (reset) // RQ9
      rx_valid |-> rx_data == $past(bus_in.data))
      else $error("Received byte differs from the bus byte");
endmodule
`default_nettype wire

// >>> tb/bus_ctl_model.sv
/*
 Behavioural bus controller that sends command and data bytes.
 Assumes a rising-edge mclk; each byte is a one-cycle valid strobe.
*/
`default_nettype none
module bus_ctl_model
   import listen_addr_pkg::*;
(
   input wire logic mclk,
   output var bus_byte_s bus_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial bus_out = '{atn: 1'b0, valid: 1'b0, data: 8'h00};
   // Released data lines show the inverse, so a stale byte never looks valid
   task automatic send(input logic atn, input logic [7:0] d);
      @(posedge mclk);
      #1 bus_out = '{atn: atn, valid: 1'b1, data: d};
      @(posedge mclk);
      #1 bus_out = '{atn: 1'b0, valid: 1'b0, data: ~d};
   endtask
endmodule
`default_nettype wire

// >>> tb/tb_listen_addr_config.sv
/*
 Self-checking bench for the listen address block.
 Assumes the package and the bus controller model are compiled first.
*/
`default_nettype none
module tb_listen_addr_config;
   import listen_addr_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [4:0] sw = 5'h00;
   bus_byte_s bus_in;
   logic [4:0] listen_addr;
   logic [7:0] listen_char, rx_data, d, o;
   logic addr_loaded, switch_invalid, listening, talk_enable, rx_valid;
   logic [31:0] seed = 32'hF919;
   logic [4:0] s, a;
   int failures = 0;
   int checked = 0;
   int n;
   int exp_q[$];
   bit model_listen = 1'b0;
   listen_addr_config i_listen_addr_config (.mclk(mclk), .reset(reset),
      .address_switch_lsb(sw[0]), .address_switch_mid(sw[3:1]),
      .address_switch_msb(sw[4]), .bus_in(bus_in), .listen_addr(listen_addr),
      .listen_char(listen_char), .addr_loaded(addr_loaded),
      .switch_invalid(switch_invalid), .listening(listening),
      .talk_enable(talk_enable), .rx_data(rx_data), .rx_valid(rx_valid));
   bus_ctl_model i_bus_ctl_model (.mclk(mclk), .bus_out(bus_in));
   initial forever #5 mclk = ~mclk;
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         $display("unexpected %s expected %h seen %h", name, exp, seen);
         failures++;
      end
   endtask
   // Looked at half a cycle after the launching edge, where outputs are settled
   always @(negedge mclk)
      if (rx_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("rx_valid", 8'h01, 8'h00);
         else
            check("rx_data", rx_data, 8'(exp_q.pop_front()));
      end
   // Listener model: only bytes sent while addressed are expected back
   task automatic put(input logic atn, input logic [7:0] b);
      if (atn && b == 8'h3F)
         model_listen = 1'b0;
      else if (atn && b == 8'h20 + {3'h0, a})
         model_listen = 1'b1;
      else if (!atn && model_listen)
         exp_q.push_back(int'(b));
      i_bus_ctl_model.send(atn, b);
   endtask
   task automatic tally_and_finish();
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic load(input logic [4:0] v);
      sw = v;
      reset = 1'b1;
      model_listen = 1'b0;
      repeat (5) @(posedge mclk);
      check("preset", {3'h0, listen_addr}, 8'h07);
      check("loaded_in_reset", {7'h00, addr_loaded}, 8'h00);
      check("pending", 8'(exp_q.size()), 8'h00);
      exp_q.delete();
      #1 reset = 1'b0;
      n = 0;
      while (addr_loaded !== 1'b1 && n < 20)
      begin
         @(posedge mclk);
         #1 n++;
      end
      if (n == 20)
      begin
         failures++;
         tally_and_finish();
      end
      check("load_cycles", n[7:0], 8'h05);
   endtask
   initial
   begin
      for (int i = 0; i < 8; i++)
      begin
         seed = xorshift(seed);
         s = (i < 4) ? ((i == 0) ? 5'h00 : (i == 1) ? 5'h07 : (i == 2) ? 5'h1E : 5'h1F)
            : seed[4:0];
         a = (s == 5'h1F) ? 5'h1E : s;
         load(s);
         check("addr", {3'h0, listen_addr}, {3'h0, a});
         check("char", listen_char, 8'h20 + {3'h0, a});
         check("invalid", {7'h00, switch_invalid}, {7'h00, s > 5'h1E});
         sw = ~s;
         repeat (3) @(posedge mclk);
         check("held", {3'h0, listen_addr}, {3'h0, a});
         d = seed[15:8];
         o = 8'h20 + {3'h0, (a == 5'h1E) ? 5'h00 : a + 5'h01};
         put(1'b0, d);
         check("stray", {7'h00, rx_valid}, 8'h00);
         put(1'b1, o);
         check("other", {7'h00, listening}, 8'h00);
         check("other_model", {7'h00, listening}, {7'h00, model_listen});
         put(1'b1, 8'h20 + {3'h0, a});
         check("listen", {7'h00, listening}, 8'h01);
         put(1'b0, d);
         check("rx_valid", {7'h00, rx_valid}, 8'h01);
         check("rx_data", rx_data, d);
         check("talk", {7'h00, talk_enable}, 8'h00);
         put(1'b1, o);
         check("still_listening", {7'h00, listening}, {7'h00, model_listen});
         put(1'b1, 8'h3F);
         check("unlistened", {7'h00, listening}, {7'h00, model_listen});
         put(1'b0, ~d);
         check("unlisten", {7'h00, rx_valid}, 8'h00);
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire
